// [rtl/trs_pkg.sv]
// Package of the request stream driver: widths, offsets, fields, types.
// Assumes one clock domain and an AXI4-Lite register port.
package trs_pkg;
  localparam int unsigned DATA_W    = 512;  // Request and completion data.
  localparam int unsigned RQ_USER_W = 137;  // Request sideband.
  localparam int unsigned KEEP_W    = 16;   // Dword keep bits.
  localparam int unsigned SEQ_W     = 6;    // Sequence numbers.
  localparam int unsigned TAG_W     = 8;    // One allocated tag.
  localparam int unsigned TAG_DEPTH = 4;    // Tags kept for software.
  localparam int unsigned ADDR_W    = 4;    // Register byte address.
  // Register byte offsets.
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] TAGS_OFS = 4'h8;
  localparam logic [3:0] CCFG_OFS = 4'hc;
  // Reset values.
  localparam logic [31:0] CTRL_RST = 32'h0;
  localparam logic [31:0] CCFG_RST = 32'h0;
  // Control register fields.
  localparam int CTL_GO   = 0;
  localparam int CTL_PACK = 1;
  localparam int CTL_PAR  = 2;
  localparam int CTL_NP   = 3;
  localparam int CTL_SEQ  = 4;
  localparam int CTL_LEN  = 10;
  localparam int CTL_ABT  = 14;
  localparam int CTL_KEEP = 18;
  // Completion configuration fields.
  localparam int CC_END1  = 0;
  localparam int CC_ARM   = 4;
  // Request sideband fields.
  localparam int SB_SOP   = 20;
  localparam int SB_SOP0P = 22;
  localparam int SB_EOP   = 26;
  localparam int SB_EOP0P = 28;
  localparam int SB_ABORT = 36;
  // Start and end flag codes, lane code.
  localparam logic [1:0] FLAG_NONE = 2'h0;
  localparam logic [1:0] FLAG_ONE  = 2'h1;
  localparam logic [1:0] FLAG_TWO  = 2'h3;
  localparam logic [1:0] FLAG_BAD  = 2'h2;
  localparam logic [1:0] LANE_0    = 2'h0;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Stream sequencer states.
  typedef enum logic [0:0] {TRS_IDLE = 1'b0, TRS_SEND = 1'b1} trs_state_e;
  // Tail of the completion sideband, bits 80:12.
  typedef struct packed {
    logic [63:0] parity;      // Odd parity per data byte.
    logic        abort;       // Packet abort flag.
    logic [3:0]  end1_ofs;    // Second end Dword offset.
  } trs_cc_tail_s;
endpackage

// [rtl/trs_parity.sv]
// Odd parity generator, one bit per data byte.
// Assumes purely combinational use on the same clock.
`timescale 1ns/1ps
`default_nettype none
module trs_parity #(
  parameter int BYTES = 64
) (
  input  wire logic [8*BYTES-1:0] data,   // Data to protect.
  input  wire logic               enable, // Zero output when low.
  output logic      [BYTES-1:0]   parity  // Odd parity bits.
);
  // Each bit makes its byte plus itself hold an odd count of ones.
  always_comb begin
    for (int i = 0; i < BYTES; i++) begin
      parity[i] = enable & ~(^data[8*i +: 8]);
    end
  end
endmodule // trs_parity
`default_nettype wire

// [rtl/trs_driver.sv]
// Request stream driver with completion sideband tail and tag capture.
// Assumes the core on the same clock and software on AXI4-Lite.
// Function
// - Second end offset only in packing mode
// - Abort flag marks erroneous packet data
// - No abort in first beat; stays sticky (the completion tail drops it once one aborted beat transfers)
// - Abort only with valid, held until ready
// - No new packet where aborted one ends
// - Parity bits odd per byte, else zero
// - 512-bit data, 137-bit sideband with valid
// - End marker on last beat
// - Keep bits contiguous, ones except last beat
// - Packing mode uses start/end flags
// - Valid held for whole packet
// - Hold beat until ready
// - Capture core tags for completions
// - Pair tags with requests in order
// - Attach six-bit sequence number
// - Flag codes 00, 01, 11 only
// - First packet starts at lane 0
`timescale 1ns/1ps
`default_nettype none
module trs_driver
  import trs_pkg::*;
(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [trs_pkg::ADDR_W-1:0]   s_axil_awaddr,
  input  wire logic                         s_axil_awvalid,
  output logic                              s_axil_awready,
  input  wire logic [31:0]                  s_axil_wdata,
  input  wire logic [3:0]                   s_axil_wstrb,
  input  wire logic                         s_axil_wvalid,
  output logic                              s_axil_wready,
  output logic      [1:0]                   s_axil_bresp,
  output logic                              s_axil_bvalid,
  input  wire logic                         s_axil_bready,
  input  wire logic [trs_pkg::ADDR_W-1:0]   s_axil_araddr,
  input  wire logic                         s_axil_arvalid,
  output logic                              s_axil_arready,
  output logic      [31:0]                  s_axil_rdata,
  output logic      [1:0]                   s_axil_rresp,
  output logic                              s_axil_rvalid,
  input  wire logic                         s_axil_rready,
  output logic [trs_pkg::DATA_W-1:0]        request_input_data,
  output logic [trs_pkg::RQ_USER_W-1:0]     request_input_sideband,
  output logic                              request_end_marker,
  output logic [trs_pkg::KEEP_W-1:0]        request_dword_keep,
  output logic                              request_valid,
  input  wire logic                         request_ready,
  output logic [trs_pkg::SEQ_W-1:0]         request_seq_in,
  input  wire logic [1:0]                   alloc_tag_valid,
  input  wire logic [2*trs_pkg::TAG_W-1:0]  alloc_tag_out,
  input  wire logic [trs_pkg::SEQ_W-1:0]    progress_seq_out_a,
  input  wire logic [trs_pkg::SEQ_W-1:0]    progress_seq_out_b,
  input  wire logic                         progress_seq_valid_a,
  input  wire logic                         progress_seq_valid_b,
  input  wire logic [trs_pkg::DATA_W-1:0]   cc_data,
  input  wire logic                         cc_valid,
  input  wire logic                         cc_ready,
  input  wire logic                         cc_first_beat,
  output trs_pkg::trs_cc_tail_s             completion_sideband_tail
);
  import trs_pkg::*;

  // Merges a write into a register under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  logic [31:0]    ctrl_reg;        // Packet command and modes.
  logic [31:0]    ccfg_reg;        // Completion tail settings.
  logic           bvalid_reg;      // Write answer pending.
  logic [1:0]     bresp_reg;       // Write answer code.
  logic           rvalid_reg;      // Read answer pending.
  logic [1:0]     rresp_reg;       // Read answer code.
  logic [31:0]    rdata_reg;       // Read answer data.
  logic           start_reg;       // One-cycle packet start.
  logic           cc_arm_reg;      // Abort armed for completions.
  trs_state_e     state_reg;       // Stream sequencer state.
  logic [3:0]     beat_reg;        // Beat being offered.
  logic [7:0]     tag_cnt_reg;     // Tags captured so far.
  logic [1:0]     tag_ptr_reg;     // Next tag slot.
  logic [TAG_W-1:0] tag_mem [TAG_DEPTH]; // Tags in request order.
  logic           tag_err_reg;     // Reserved tag code seen.
  logic [SEQ_W-1:0] last_seq_reg;  // Latest progress number.
  logic [7:0]     seq_cnt_reg;     // Progress numbers seen.
  logic           wr_take;         // Write address and data taken.
  logic           ar_take;         // Read address taken.
  logic           hs;              // Request beat transfers.
  logic           last_beat;       // Offered beat ends the packet.
  logic [3:0]     len;             // Beats in packet minus one.
  logic [3:0]     abt_beat;        // Beat that starts the abort.
  logic [3:0]     keep_last;       // Dwords in last beat, 0 is 16.
  logic [63:0]    cc_par;          // Parity of completion data.

  assign len       = ctrl_reg[CTL_LEN +: 4];
  assign abt_beat  = ctrl_reg[CTL_ABT +: 4];
  assign keep_last = ctrl_reg[CTL_KEEP +: 4];
  assign hs        = request_valid & request_ready;
  assign last_beat = (beat_reg == len);

  // Write channel: both halves taken together, one write at a time.
  assign wr_take        = s_axil_awvalid & s_axil_wvalid & ~bvalid_reg;
  assign s_axil_awready = wr_take;
  assign s_axil_wready  = wr_take;
  assign s_axil_bvalid  = bvalid_reg;
  assign s_axil_bresp   = bresp_reg;

  // Write answer follows one cycle after the take.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_take) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (s_axil_awaddr == CTRL_OFS || s_axil_awaddr == CCFG_OFS) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axil_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Configuration writes; the go bit never stores, it only starts.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg  <= CTRL_RST;
      ccfg_reg  <= CCFG_RST;
      start_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (wr_take && s_axil_awaddr == CTRL_OFS && state_reg == TRS_IDLE && !start_reg) begin
        ctrl_reg          <= merge(ctrl_reg, s_axil_wdata, s_axil_wstrb);
        ctrl_reg[CTL_GO]  <= 1'b0;
        start_reg         <= s_axil_wstrb[0] & s_axil_wdata[CTL_GO];
      end
      if (wr_take && s_axil_awaddr == CCFG_OFS) begin
        ccfg_reg <= merge(ccfg_reg, s_axil_wdata, s_axil_wstrb);
      end
    end
  end

  // Read channel: answer one cycle after the address is taken.
  assign ar_take        = s_axil_arvalid & ~rvalid_reg;
  assign s_axil_arready = ar_take;
  assign s_axil_rvalid  = rvalid_reg;
  assign s_axil_rresp   = rresp_reg;
  assign s_axil_rdata   = rdata_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      case (s_axil_araddr)
        CTRL_OFS: rdata_reg <= ctrl_reg;
        STAT_OFS: rdata_reg <= {seq_cnt_reg, 2'h0, last_seq_reg, tag_cnt_reg,
                                5'h0, tag_err_reg, cc_arm_reg, (state_reg == TRS_SEND)};
        TAGS_OFS: rdata_reg <= {tag_mem[3], tag_mem[2], tag_mem[1], tag_mem[0]};
        CCFG_OFS: rdata_reg <= ccfg_reg;
        default: begin
          rdata_reg <= 32'h0;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (s_axil_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Keep bits of a beat: all ones, or the low Dwords of the last beat.
  function automatic logic [KEEP_W-1:0] keep_of(input logic lst, input logic [3:0] k);
    logic [KEEP_W-1:0] m;
    m = {KEEP_W{1'b1}};
    if (lst && k != 4'h0) begin
      m = KEEP_W'((17'h1 << k) - 17'h1);
    end
    return m;
  endfunction

  // Sideband of a beat: one packet per beat, starting at lane 0.
  function automatic logic [RQ_USER_W-1:0] sb_of(input logic [3:0] b, input logic lst,
                                                 input logic [3:0] k, input logic [3:0] ab);
    logic [RQ_USER_W-1:0] s;
    s = '0;
    s[SB_SOP +: 2]   = (b == 4'h0) ? FLAG_ONE : FLAG_NONE;
    s[SB_SOP0P +: 2] = LANE_0;
    s[SB_EOP +: 2]   = lst ? FLAG_ONE : FLAG_NONE;
    s[SB_EOP0P +: 4] = lst ? (k - 4'h1) : 4'h0;
    s[SB_ABORT]      = (ab != 4'h0) && (b >= ab);
    return s;
  endfunction

  // Stream sequencer: a beat changes only when it transfers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg              <= TRS_IDLE;
      beat_reg               <= 4'h0;
      request_valid          <= 1'b0;
      request_input_data     <= '0;
      request_input_sideband <= '0;
      request_end_marker     <= 1'b0;
      request_dword_keep     <= '0;
      request_seq_in         <= '0;
    end else begin
      case (state_reg)
        TRS_IDLE: begin
          if (start_reg) begin
            state_reg              <= TRS_SEND;
            beat_reg               <= 4'h0;
            request_valid          <= 1'b1;
            request_input_data     <= {16{18'h0, ctrl_reg[CTL_SEQ +: 6], 8'h0}};
            request_input_sideband <= sb_of(4'h0, len == 4'h0, keep_last, abt_beat);
            request_end_marker     <= (len == 4'h0);
            request_dword_keep     <= keep_of(len == 4'h0, keep_last);
            request_seq_in         <= ctrl_reg[CTL_SEQ +: 6];
          end
        end
        TRS_SEND: begin
          if (hs) begin
            if (last_beat) begin
              state_reg          <= TRS_IDLE;
              request_valid      <= 1'b0;
              request_end_marker <= 1'b0;
            end else begin
              beat_reg               <= beat_reg + 4'h1;
              request_input_data     <= {16{18'h0, ctrl_reg[CTL_SEQ +: 6], 4'h0, beat_reg + 4'h1}};
              request_input_sideband <= sb_of(beat_reg + 4'h1, beat_reg + 4'h1 == len, keep_last, abt_beat);
              request_end_marker     <= (beat_reg + 4'h1 == len);
              request_dword_keep     <= keep_of(beat_reg + 4'h1 == len, keep_last);
            end
          end
        end
        default: state_reg <= TRS_IDLE;
      endcase
    end
  end

  // Tag capture in transfer order; the low byte is the earlier request.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tag_cnt_reg <= 8'h0;
      tag_ptr_reg <= 2'h0;
      tag_err_reg <= 1'b0;
      for (int i = 0; i < TAG_DEPTH; i++) begin
        tag_mem[i] <= '0;
      end
    end else begin
      case (alloc_tag_valid)
        FLAG_ONE: begin
          tag_mem[tag_ptr_reg] <= alloc_tag_out[7:0];
          tag_ptr_reg          <= tag_ptr_reg + 2'h1;
          tag_cnt_reg          <= tag_cnt_reg + 8'h1;
        end
        FLAG_TWO: begin
          tag_mem[tag_ptr_reg]        <= alloc_tag_out[7:0];
          tag_mem[tag_ptr_reg + 2'h1] <= alloc_tag_out[15:8];
          tag_ptr_reg                 <= tag_ptr_reg + 2'h2;
          tag_cnt_reg                 <= tag_cnt_reg + 8'h2;
        end
        FLAG_BAD: tag_err_reg <= 1'b1;
        default: tag_err_reg <= tag_err_reg;
      endcase
    end
  end

  // Progress numbers; the second output is the later one when both pulse.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_seq_reg <= '0;
      seq_cnt_reg  <= 8'h0;
    end else begin
      if (progress_seq_valid_b) begin
        last_seq_reg <= progress_seq_out_b;
      end else if (progress_seq_valid_a) begin
        last_seq_reg <= progress_seq_out_a;
      end
      seq_cnt_reg <= seq_cnt_reg + 8'(progress_seq_valid_a) + 8'(progress_seq_valid_b);
    end
  end

  // Completion abort arming; cleared once an aborted beat transfers.
  // The completion source must not start a packet in that ending beat.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cc_arm_reg <= 1'b0;
    end else if (wr_take && s_axil_awaddr == CCFG_OFS && s_axil_wstrb[0] && s_axil_wdata[CC_ARM]) begin
      cc_arm_reg <= 1'b1;
    end else if (completion_sideband_tail.abort && cc_ready) begin
      cc_arm_reg <= 1'b0;
    end
  end

  trs_parity #(.BYTES(64)) u_cc_parity (
    .data   (cc_data),
    .enable (ctrl_reg[CTL_PAR]),
    .parity (cc_par)
  );

  // Completion tail: abort only in a non-first beat while valid.
  always_comb begin
    completion_sideband_tail.parity   = cc_par;
    completion_sideband_tail.abort    = cc_arm_reg & cc_valid & ~cc_first_beat;
    completion_sideband_tail.end1_ofs = ctrl_reg[CTL_PACK] ? ccfg_reg[CC_END1 +: 4] : 4'h0;
  end

  // Checks on what this driver produces.
  chk_rq_hold_beat: assert property (@(posedge aclk) disable iff (!aresetn)
    request_valid && !request_ready |=> request_valid && $stable(request_input_data)
      && $stable(request_input_sideband) && $stable(request_dword_keep) && $stable(request_end_marker))
    else $error("Request beat changed before ready.");
  chk_rq_valid_run: assert property (@(posedge aclk) disable iff (!aresetn)
    hs && !request_end_marker |=> request_valid)
    else $error("Valid dropped inside a packet.");
  chk_abort_not_first: assert property (@(posedge aclk) disable iff (!aresetn)
    request_valid && request_input_sideband[SB_SOP +: 2] != FLAG_NONE |-> !request_input_sideband[SB_ABORT])
    else $error("Abort raised in first beat.");
  chk_abort_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    hs && request_input_sideband[SB_ABORT] && !request_end_marker |=> request_input_sideband[SB_ABORT])
    else $error("Abort dropped before packet end.");
  chk_flag_codes: assert property (@(posedge aclk) disable iff (!aresetn)
    request_valid |-> request_input_sideband[SB_SOP +: 2] != FLAG_BAD
      && request_input_sideband[SB_EOP +: 2] != FLAG_BAD && request_input_sideband[SB_SOP0P +: 2] == LANE_0)
    else $error("Illegal start or end flag code.");
  chk_end_marker: assert property (@(posedge aclk) disable iff (!aresetn)
    request_valid |-> request_end_marker == (request_input_sideband[SB_EOP +: 2] == FLAG_ONE))
    else $error("End marker and end flag disagree.");
  chk_keep_contig: assert property (@(posedge aclk) disable iff (!aresetn)
    request_valid |-> ((request_dword_keep + 16'h1) & request_dword_keep) == 16'h0
      && request_dword_keep[0] && (request_end_marker || &request_dword_keep))
    else $error("Keep bits not contiguous.");
  chk_cc_abort_valid: assert property (@(posedge aclk) disable iff (!aresetn)
    completion_sideband_tail.abort && !cc_ready && $stable(cc_valid) |=> completion_sideband_tail.abort)
    else $error("Completion abort dropped before ready.");
  chk_cc_end1_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_reg[CTL_PACK] |-> completion_sideband_tail.end1_ofs == 4'h0)
    else $error("Second end offset driven without packing.");
  chk_tag_pairs: assert property (@(posedge aclk) disable iff (!aresetn)
    alloc_tag_valid == FLAG_TWO |=> tag_cnt_reg == $past(tag_cnt_reg) + 8'h2)
    else $error("Two tags not both captured.");

  cov_backpressure: cover property (@(posedge aclk) disable iff (!aresetn)
    request_valid && !request_ready ##1 hs);
  cov_aborted_pkt: cover property (@(posedge aclk) disable iff (!aresetn)
    hs && request_input_sideband[SB_ABORT] && request_end_marker);
  cov_two_tags: cover property (@(posedge aclk) disable iff (!aresetn) alloc_tag_valid == FLAG_TWO);
  cov_two_seqs: cover property (@(posedge aclk) disable iff (!aresetn)
    progress_seq_valid_a && progress_seq_valid_b);
endmodule // trs_driver
`default_nettype wire

// [dv/trs_core_model.sv]
// Core-side model: paces ready, hands out tags and progress numbers.
// Assumes the driver on the same clock and reset.
`timescale 1ns/1ps
`default_nettype none
module trs_core_model
  import trs_pkg::*;
#(
  parameter logic [7:0] TAG_BASE = 8'h20
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      slow,
  input  wire logic                      request_valid,
  input  wire logic                      request_end_marker,
  input  wire logic [trs_pkg::SEQ_W-1:0] request_seq_in,
  output logic                           request_ready,
  output logic      [1:0]                alloc_tag_valid,
  output logic      [2*trs_pkg::TAG_W-1:0] alloc_tag_out,
  output logic      [trs_pkg::SEQ_W-1:0] progress_seq_out_a,
  output logic                           progress_seq_valid_a,
  output logic      [trs_pkg::SEQ_W-1:0] progress_seq_out_b,
  output logic                           progress_seq_valid_b
);
  import trs_pkg::*;
  logic [1:0] pace;             // Stall pattern counter.
  logic [7:0] tag_n;            // Next tag to allocate.
  logic       hit;              // Last beat of a packet taken.
  logic       held;             // A slow-mode tag waits for a partner.
  logic [SEQ_W-1:0] held_seq;   // Sequence number of the waiting request.
  // Ready stays high, or comes one cycle in four when slow.
  assign request_ready = !slow || (pace == 2'h3);
  assign hit = request_valid && request_ready && request_end_marker;
  // One tag per packet, then its progress number; idle outputs toggle.
  // In slow mode one tag is held back so that the next goes out with it as a pair.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pace                 <= 2'h0;
      tag_n                <= TAG_BASE;
      held                 <= 1'b0;
      held_seq             <= '0;
      alloc_tag_valid      <= 2'h0;
      alloc_tag_out        <= '0;
      progress_seq_valid_a <= 1'b0;
      progress_seq_out_a   <= '0;
      progress_seq_valid_b <= 1'b0;
      progress_seq_out_b   <= '0;
    end else begin
      pace            <= pace + 2'h1;
      alloc_tag_valid <= FLAG_NONE;
      alloc_tag_out   <= ~alloc_tag_out;
      if (hit && slow && !held) begin
        held     <= 1'b1;
        held_seq <= request_seq_in;
      end else if (hit && held) begin
        held            <= 1'b0;
        alloc_tag_valid <= FLAG_TWO;
        alloc_tag_out   <= {tag_n + 8'h1, tag_n};
      end else if (hit) begin
        alloc_tag_valid <= FLAG_ONE;
        alloc_tag_out   <= {8'h00, tag_n};
      end
      progress_seq_valid_a <= alloc_tag_valid[0];
      progress_seq_out_a   <= alloc_tag_valid[1] ? held_seq :
                              (alloc_tag_valid[0] ? request_seq_in : ~progress_seq_out_a);
      progress_seq_valid_b <= alloc_tag_valid[1];
      progress_seq_out_b   <= alloc_tag_valid[1] ? request_seq_in : ~progress_seq_out_b;
      tag_n <= tag_n + 8'(alloc_tag_valid[0]) + 8'(alloc_tag_valid[1]);
    end
  end
endmodule // trs_core_model
`default_nettype wire

// [dv/tlp_request_stream_sink_test.sv]
// Testbench of the request stream driver through its register port.
// Assumes the core model on one 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tlp_request_stream_sink_test;
  import trs_pkg::*;
  logic aclk = 0, aresetn = 0, slow = 0, cc_valid = 0, cc_ready = 0, cc_first_beat = 0; // Clock and controls.
  logic s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0, s_axil_arvalid = 0, s_axil_rready = 0;
  logic [ADDR_W-1:0] s_axil_awaddr = '0, s_axil_araddr = '0; // Register addresses.
  logic [31:0] s_axil_wdata = '0, s_axil_rdata, rv; // Register data.
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid; // Slave answers.
  logic [1:0] s_axil_bresp, s_axil_rresp, alloc_tag_valid, resp; // Codes.
  logic [DATA_W-1:0] request_input_data, cc_data = '0; // Data buses.
  logic [RQ_USER_W-1:0] request_input_sideband; // Request sideband.
  logic request_end_marker, request_valid, request_ready, progress_seq_valid_a, progress_seq_valid_b; // Framing.
  logic [KEEP_W-1:0] request_dword_keep; // Keep bits.
  logic [SEQ_W-1:0] request_seq_in, progress_seq_out_a, progress_seq_out_b, exp_seq; // Sequence numbers.
  logic [2*TAG_W-1:0] alloc_tag_out; // Allocated tags.
  trs_cc_tail_s completion_sideband_tail; // Completion tail.
  logic [3:0] beat = 0, exp_len, exp_abt, exp_idx; // Expected framing.
  logic [63:0] par; // Expected parity.
  logic last; // Last beat flag.
  int num_errors = 0, check_count = 0, cycles = 0; // Counters.
  // Clock of 20 ns.
  always #10 aclk = ~aclk;
  trs_driver trs_driver_i (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata,
    .s_axil_wstrb(4'hf), .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
    .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid,
    .s_axil_rready, .request_input_data, .request_input_sideband, .request_end_marker, .request_dword_keep,
    .request_valid, .request_ready, .request_seq_in, .alloc_tag_valid, .alloc_tag_out, .progress_seq_out_a,
    .progress_seq_out_b, .progress_seq_valid_a, .progress_seq_valid_b, .cc_data, .cc_valid,
    .cc_ready, .cc_first_beat, .completion_sideband_tail);
  trs_core_model #(.TAG_BASE(8'h20)) trs_core_model_i (.aclk, .aresetn, .slow, .request_valid,
    .request_end_marker, .request_seq_in, .request_ready, .alloc_tag_valid, .alloc_tag_out,
    .progress_seq_out_a, .progress_seq_valid_a, .progress_seq_out_b, .progress_seq_valid_b);
  // Compares one value and counts it.
  task automatic check(input logic [68:0] seen, input logic [68:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic conclude();
    if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Register write: address and data together, then the response.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axil_awaddr, s_axil_wdata} <= {a, d};
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready} <= 3'b111;
    do @(posedge aclk); while (s_axil_awready !== 1'b1);
    {s_axil_awvalid, s_axil_wvalid} <= 2'b00;
    do @(posedge aclk); while (s_axil_bvalid !== 1'b1);
    resp = s_axil_bresp;
    s_axil_bready <= 1'b0;
  endtask
  // Register read.
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axil_araddr <= a;
    {s_axil_arvalid, s_axil_rready} <= 2'b11;
    do @(posedge aclk); while (s_axil_arready !== 1'b1);
    s_axil_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axil_rvalid !== 1'b1);
    {rv, resp} = {s_axil_rdata, s_axil_rresp};
    s_axil_rready <= 1'b0;
  endtask
  // Starts one packet and waits until its last beat has gone; tags may come later.
  task automatic send(input logic [3:0] len, input logic [3:0] abt, input logic [3:0] dw, input logic [5:0] sq);
    {exp_len, exp_abt, exp_seq, exp_idx} = {len, abt, sq, dw - 4'h1};
    wr(CTRL_OFS, {10'h0, dw, abt, len, sq, 4'h1});
    check(resp, RESP_OKAY);
    do @(posedge aclk); while (request_valid !== 1'b1);
    do @(posedge aclk); while (request_valid !== 1'b0);
  endtask
  // Checks each transferred beat.
  always @(posedge aclk) if (request_valid === 1'b1 && request_ready === 1'b1) begin
    last = (beat == exp_len);
    check(request_end_marker, last);
    check(request_input_sideband[27:26], last ? FLAG_ONE : FLAG_NONE);
    check(request_input_sideband[31:28], last ? exp_idx : 4'h0);
    check(request_input_sideband[21:20], beat == 0 ? FLAG_ONE : FLAG_NONE);
    check(request_input_sideband[23:22], LANE_0);
    check(request_dword_keep, last ? 16'hffff >> (4'hf - exp_idx) : 16'hffff);
    check(request_input_sideband[SB_ABORT], exp_abt != 0 && beat >= exp_abt);
    check(request_input_data[31:0], {18'h0, exp_seq, 4'h0, beat});
    beat = last ? 4'h0 : beat + 4'h1;
  end
  // Cuts a hang short.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end
  // Main sequence.
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL_OFS);
    check(rv, CTRL_RST);
    check(resp, RESP_OKAY);
    rd(STAT_OFS);
    check(rv, 32'h0);
    wr(TAGS_OFS, 32'h1);
    check(resp, RESP_SLVERR);
    send(4'h2, 4'h0, 4'h3, 6'h05);
    slow <= 1'b1;
    send(4'h0, 4'h0, 4'h0, 6'h2a);
    send(4'h3, 4'h2, 4'h7, 6'h3f);
    rd(STAT_OFS);
    check(rv[31:8], {8'h03, 2'h0, 6'h3f, 8'h03});
    rd(TAGS_OFS);
    check(rv, 32'h0022_2120);
    wr(CTRL_OFS, 32'h6);
    wr(CCFG_OFS, 32'h19);
    @(posedge aclk);
    cc_data <= {16{32'h0137_80fe}};
    {cc_valid, cc_first_beat} <= 2'b11;
    @(posedge aclk);
    #1;
    for (int i = 0; i < 64; i++) par[i] = ~^cc_data[8*i +: 8];
    check(completion_sideband_tail, {par, 1'b0, 4'h9});
    check(completion_sideband_tail.parity, par);
    @(posedge aclk);
    cc_first_beat <= 1'b0;
    @(posedge aclk);
    cc_ready <= 1'b1;
    #1;
    check(completion_sideband_tail.abort, 1'b1);
    @(posedge aclk);
    #1;
    check(completion_sideband_tail.abort, 1'b0);
    rd(STAT_OFS);
    check(rv[2:0], 3'h0);
    wr(CTRL_OFS, 32'h0);
    #1;
    check(completion_sideband_tail, '0);
    conclude();
  end
endmodule // tlp_request_stream_sink_test
`default_nettype wire
